// file: rtl/adc_device.sv
// converter control end: power modes, conversion timer and read-only serial port
`timescale 1ns/1ns
`default_nettype none

// Function
// R1: starts powered down, wakes in 1 us
// R2: start-pin rising edge wakes the device
// R3: falling edge holds and converts for 4.5 us
// R4: conversion end loads result, samples start pin
// R5: start still low at end powers down
// R6: host raises start before end to stay up
// R7: early falling edge waits out power-up first
// R8: rising edge enables the serial port
// R9: early read returns previous result
// R10: load deferred until running read finishes
// R11: serial port works while powered down
// R12: host never spans a read over rise
// R13: each rising edge clears bit counter
// R14: extra serial clocks after eight ignored
// R15: eighth falling clock resets the counter
// R16: bits appear on rising serial clock edges
// R17: data released on eighth falling edge
// R18: nothing shifts before a start rising edge
// R19: continuous or burst serial clock both work
// R20: host holds start low at power-on
// R21: straight binary code, step is reference/256
// R22: eight bits leave most significant first
module adc_device
    import adc_pkg::*;
(
    input  wire logic    CLK_I,
    input  wire logic    RESET_N_I,
    adc_link_if.device   LINK,
    input  wire result_t ANALOG_CODE_I,
    output logic         POWERED_O,
    output logic         CONVERTING_O,
    output result_t      RESULT_O
);

    // ==========================================================
    // pin synchronisers
    logic cs_level;
    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;

    edge_sync #(.RESET_VAL(1'b0)) u_cs_sync (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .async_i   (LINK.conversion_start_n),
        .level_o   (cs_level),
        .rise_o    (cs_rise),
        .fall_o    (cs_fall)
    );

    // the serial clock may stop between bursts; only its edges matter
    edge_sync #(.RESET_VAL(1'b0)) u_sclk_sync ( // R19
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .async_i   (LINK.sclk),
        .level_o   (),
        .rise_o    (sclk_rise),
        .fall_o    (sclk_fall)
    );

    // ==========================================================
    // power and conversion state
    dev_state_e state_q;
    dev_state_e state_d;
    tmr_t       tmr_q;
    tmr_t       tmr_d;
    logic       pend_conv_q;
    logic       pend_conv_d;
    result_t    hold_q;
    result_t    hold_d;
    result_t    result_q;
    result_t    result_d;
    logic       pend_load_q;
    logic       pend_load_d;
    logic       conv_end;

    // ==========================================================
    // serial port state
    result_t    shreg_q;
    result_t    shreg_d;
    bitcnt_t    bitcnt_q;
    bitcnt_t    bitcnt_d;
    logic       port_en_q;
    logic       port_en_d;
    logic       dout_q;
    logic       dout_d;
    logic       oe_n_q;
    logic       oe_n_d;
    logic       reading;

    assign conv_end = (state_q == DEV_CONVERT) && (tmr_q == TMR_ONE);
    assign reading  = port_en_q && (bitcnt_q != BIT_ZERO);

    // ==========================================================
    // power and conversion next state
    always_comb begin
        state_d     = state_q;
        tmr_d       = tmr_q;
        pend_conv_d = pend_conv_q;
        hold_d      = hold_q;
        result_d    = result_q;
        pend_load_d = pend_load_q;
        case (state_q)
            DEV_OFF: begin
                if (cs_rise) begin
                    state_d     = DEV_POWERUP; // R2
                    tmr_d       = POWERUP_TMR; // R1
                    pend_conv_d = 1'b0;
                end
            end
            DEV_POWERUP: begin
                if (cs_fall) begin
                    pend_conv_d = 1'b1; // R7
                end
                if (tmr_q == TMR_ONE) begin
                    if (pend_conv_q || cs_fall) begin
                        state_d     = DEV_CONVERT; // R7
                        tmr_d       = CONV_TMR;
                        hold_d      = ANALOG_CODE_I;
                        pend_conv_d = 1'b0;
                    end else begin
                        state_d = DEV_READY;
                        tmr_d   = TMR_ZERO;
                    end
                end else begin
                    tmr_d = tmr_q - TMR_ONE;
                end
            end
            DEV_READY: begin
                if (cs_fall) begin
                    state_d = DEV_CONVERT; // R3
                    tmr_d   = CONV_TMR; // R3
                    hold_d  = ANALOG_CODE_I; // R21
                end
            end
            DEV_CONVERT: begin
                if (conv_end) begin
                    result_d    = hold_q; // R4
                    pend_load_d = 1'b1; // R4
                    tmr_d       = TMR_ZERO;
                    // level sampled at the end picks the mode
                    if (!cs_level) begin
                        state_d = DEV_OFF; // R5
                    end else begin
                        state_d = DEV_READY;
                    end
                end else begin
                    tmr_d = tmr_q - TMR_ONE;
                end
            end
            default: begin
                state_d = DEV_OFF;
                tmr_d   = TMR_ZERO;
            end
        endcase
        // a read in flight keeps the old word stable until it is over
        // a new result in the same cycle keeps the flag set
        if (pend_load_q && !reading && !conv_end) begin
            pend_load_d = 1'b0; // R10
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q     <= DEV_OFF; // R1
            tmr_q       <= TMR_ZERO;
            pend_conv_q <= 1'b0;
            hold_q      <= RESULT_RESET;
            result_q    <= RESULT_RESET;
            pend_load_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            tmr_q       <= tmr_d;
            pend_conv_q <= pend_conv_d;
            hold_q      <= hold_d;
            result_q    <= result_d;
            pend_load_q <= pend_load_d;
        end
    end

    // ==========================================================
    // serial port next state; it never looks at the power state
    always_comb begin
        shreg_d   = shreg_q;
        bitcnt_d  = bitcnt_q;
        port_en_d = port_en_q;
        dout_d    = dout_q;
        oe_n_d    = oe_n_q;
        if (pend_load_q && !reading) begin
            shreg_d = result_q; // R9 R10
        end
        if (cs_rise) begin
            port_en_d = 1'b1; // R8
            bitcnt_d  = BIT_ZERO; // R13
        end else if (port_en_q) begin // R18 R11
            if (sclk_rise && (bitcnt_q != BIT_LAST)) begin // R14
                dout_d   = shreg_q[RESULT_BITS-1]; // R22
                // rotate so a second read of the same word still sees it
                shreg_d  = {shreg_q[RESULT_BITS-2:0], shreg_q[RESULT_BITS-1]}; // R16 R9
                oe_n_d   = 1'b0; // R16
                bitcnt_d = bitcnt_q + BIT_ONE;
            end else if (sclk_fall && (bitcnt_q == BIT_LAST)) begin
                oe_n_d    = 1'b1; // R17
                bitcnt_d  = BIT_ZERO; // R15
                port_en_d = 1'b0; // R18
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            shreg_q   <= RESULT_RESET;
            bitcnt_q  <= BIT_ZERO;
            port_en_q <= 1'b0;
            dout_q    <= 1'b0;
            oe_n_q    <= 1'b1;
        end else begin
            shreg_q   <= shreg_d;
            bitcnt_q  <= bitcnt_d;
            port_en_q <= port_en_d;
            dout_q    <= dout_d;
            oe_n_q    <= oe_n_d;
        end
    end

    // ==========================================================
    // status outputs, registered
    logic    powered_q;
    logic    converting_q;
    result_t result_out_q;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            powered_q    <= 1'b0;
            converting_q <= 1'b0;
            result_out_q <= RESULT_RESET;
        end else begin
            powered_q    <= (state_d != DEV_OFF);
            converting_q <= (state_d == DEV_CONVERT);
            result_out_q <= result_d;
        end
    end

    assign POWERED_O      = powered_q;
    assign CONVERTING_O   = converting_q;
    assign RESULT_O       = result_out_q;
    assign LINK.dout      = dout_q;
    assign LINK.dout_oe_n = oe_n_q;

endmodule : adc_device

`default_nettype wire

// file: include/adc_pkg.sv
// shared constants, types and state encodings for the converter control link
package adc_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int T_POWERUP_NS    = 1000;
    localparam int T_CONV_NS       = 4500;
    localparam int T_SCLK_HALF_NS  = 400;
    localparam int T_CS_HOLD_NS    = 500;
    localparam int T_CONV_MARGIN_NS = 500;

    function automatic int ns_to_cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc_up

    localparam int POWERUP_CYC   = ns_to_cyc_up(T_POWERUP_NS);
    localparam int CONV_CYC      = ns_to_cyc_up(T_CONV_NS);
    localparam int SCLK_HALF_CYC = ns_to_cyc_up(T_SCLK_HALF_NS);
    localparam int CS_HOLD_CYC   = ns_to_cyc_up(T_CS_HOLD_NS);
    localparam int CONV_WAIT_CYC = ns_to_cyc_up(T_CONV_NS + T_CONV_MARGIN_NS);

    // ==========================================================
    // widths and types
    localparam int RESULT_BITS = 8;
    localparam int TMR_W       = 8;
    localparam int CNT_W       = 4;

    typedef logic [RESULT_BITS-1:0] result_t;
    typedef logic [TMR_W-1:0]       tmr_t;
    typedef logic [CNT_W-1:0]       bitcnt_t;

    localparam tmr_t    POWERUP_TMR   = tmr_t'(POWERUP_CYC);
    localparam tmr_t    CONV_TMR      = tmr_t'(CONV_CYC);
    localparam tmr_t    SCLK_HALF_TMR = tmr_t'(SCLK_HALF_CYC);
    localparam tmr_t    CS_HOLD_TMR   = tmr_t'(CS_HOLD_CYC);
    localparam tmr_t    CONV_WAIT_TMR = tmr_t'(CONV_WAIT_CYC);
    localparam tmr_t    TMR_ONE       = 8'h01;
    localparam tmr_t    TMR_ZERO      = 8'h00;
    localparam bitcnt_t BIT_LAST      = bitcnt_t'(RESULT_BITS);
    localparam bitcnt_t BIT_ZERO      = 4'h0;
    localparam bitcnt_t BIT_ONE       = 4'h1;
    localparam result_t RESULT_RESET  = 8'h00;

    // ==========================================================
    // state machines
    typedef enum logic [1:0] {
        DEV_OFF,
        DEV_POWERUP,
        DEV_READY,
        DEV_CONVERT
    } dev_state_e;

    typedef enum logic [2:0] {
        HOST_IDLE,
        HOST_WAKE,
        HOST_CONV_LOW,
        HOST_CONV_WAIT,
        HOST_GAP,
        HOST_READ
    } host_state_e;

endpackage : adc_pkg

// file: include/adc_link_if.sv
// three-wire link between the converter and its serial clock master
`timescale 1ns/1ns
`default_nettype none

interface adc_link_if;
    logic conversion_start_n;
    logic sclk;
    logic dout;
    logic dout_oe_n;
    logic dout_line;

    // released line floats high through a pull-up
    assign dout_line = dout_oe_n ? 1'b1 : dout;

    modport device (
        input  conversion_start_n,
        input  sclk,
        output dout,
        output dout_oe_n
    );

    modport host (
        output conversion_start_n,
        output sclk,
        input  dout_line
    );
endinterface : adc_link_if

`default_nettype wire

// file: rtl/edge_sync.sv
// two-flop synchroniser with level and edge outputs
`timescale 1ns/1ns
`default_nettype none

module edge_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
            prev_q <= RESET_VAL;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~prev_q;
    assign fall_o  = ~sync_q & prev_q;
endmodule : edge_sync

`default_nettype wire

// file: rtl/adc_host.sv
// serial clock master end: paces conversions and reads eight result bits
`timescale 1ns/1ns
`default_nettype none

module adc_host
    import adc_pkg::*;
(
    input  wire logic CLK_I,
    input  wire logic RESET_N_I,
    input  wire logic START_I,
    input  wire logic AUTO_PD_I,
    adc_link_if.host  LINK,
    output result_t   DATA_O,
    output logic      DONE_O,
    output logic      BUSY_O
);

    // ==========================================================
    // data input synchroniser
    logic din_level;

    edge_sync #(.RESET_VAL(1'b1)) u_din_sync (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .async_i   (LINK.dout_line),
        .level_o   (din_level),
        .rise_o    (),
        .fall_o    ()
    );

    // ==========================================================
    // sequencer
    host_state_e state_q;
    host_state_e state_d;
    tmr_t        tmr_q;
    tmr_t        tmr_d;
    logic        auto_q;
    logic        auto_d;
    logic        cs_q;
    logic        cs_d;
    logic        sclk_q;
    logic        sclk_d;
    bitcnt_t     bits_q;
    bitcnt_t     bits_d;
    result_t     data_q;
    result_t     data_d;
    logic        done_q;
    logic        done_d;
    logic        busy_q;
    logic        busy_d;

    always_comb begin
        state_d = state_q;
        tmr_d   = tmr_q;
        auto_d  = auto_q;
        cs_d    = cs_q;
        sclk_d  = sclk_q;
        bits_d  = bits_q;
        data_d  = data_q;
        done_d  = 1'b0;
        if (tmr_q != TMR_ZERO) begin
            tmr_d = tmr_q - TMR_ONE;
        end
        case (state_q)
            HOST_IDLE: begin
                if (START_I) begin
                    auto_d = AUTO_PD_I;
                    tmr_d  = CS_HOLD_TMR;
                    if (cs_q) begin
                        cs_d    = 1'b0;
                        state_d = HOST_CONV_LOW;
                    end else begin
                        cs_d    = 1'b1;
                        state_d = HOST_WAKE;
                    end
                end
            end
            HOST_WAKE: begin
                if (tmr_q == TMR_ZERO) begin
                    cs_d    = 1'b0;
                    tmr_d   = CS_HOLD_TMR;
                    state_d = HOST_CONV_LOW;
                end
            end
            HOST_CONV_LOW: begin
                if (tmr_q == TMR_ZERO) begin
                    // high-speed mode raises the pin well before the end
                    cs_d    = !auto_q; // R6
                    tmr_d   = CONV_WAIT_TMR; // R9
                    state_d = HOST_CONV_WAIT;
                end
            end
            HOST_CONV_WAIT: begin
                if (tmr_q == TMR_ZERO) begin
                    cs_d    = 1'b1;
                    tmr_d   = CS_HOLD_TMR;
                    state_d = HOST_GAP;
                end
            end
            HOST_GAP: begin
                if (tmr_q == TMR_ZERO) begin
                    bits_d  = BIT_ZERO;
                    tmr_d   = SCLK_HALF_TMR;
                    state_d = HOST_READ;
                end
            end
            HOST_READ: begin
                // pin stays high through the read so no edge resets the port
                if (tmr_q == TMR_ZERO) begin // R12
                    tmr_d  = SCLK_HALF_TMR;
                    sclk_d = !sclk_q;
                    if (sclk_q) begin
                        data_d = {data_q[RESULT_BITS-2:0], din_level};
                        bits_d = bits_q + BIT_ONE;
                        if (bits_q == BIT_LAST - BIT_ONE) begin
                            done_d  = 1'b1;
                            tmr_d   = TMR_ZERO;
                            state_d = HOST_IDLE;
                        end
                    end
                end
            end
            default: begin
                state_d = HOST_IDLE;
            end
        endcase
        busy_d = (state_d != HOST_IDLE);
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q <= HOST_IDLE;
            tmr_q   <= TMR_ZERO;
            auto_q  <= 1'b0;
            cs_q    <= 1'b0; // R20
            sclk_q  <= 1'b0;
            bits_q  <= BIT_ZERO;
            data_q  <= RESULT_RESET;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            tmr_q   <= tmr_d;
            auto_q  <= auto_d;
            cs_q    <= cs_d;
            sclk_q  <= sclk_d;
            bits_q  <= bits_d;
            data_q  <= data_d;
            done_q  <= done_d;
            busy_q  <= busy_d;
        end
    end

    assign LINK.conversion_start_n = cs_q;
    assign LINK.sclk               = sclk_q;
    assign DATA_O                  = data_q;
    assign DONE_O                  = done_q;
    assign BUSY_O                  = busy_q;

endmodule : adc_host

`default_nettype wire

// file: test/adc_link_assertions.sv
// concurrent checks on the link between the host end and the converter end
`timescale 1ns/1ns
`default_nettype none

module adc_link_assertions (
    input  wire logic CLK_I,
    input  wire logic RESET_N_I,
    input  wire logic conversion_start_n,
    input  wire logic sclk,
    input  wire logic dout,
    input  wire logic dout_oe_n,
    input  wire logic dout_line
);
    // ==========================================================
    // helper state: port enable and counted serial clock rises
    logic       cs_q, cs_d, sclk_q, sclk_d, en_q, en_d;
    logic [3:0] nrise_q, nrise_d, since_q, since_d, dis_q, dis_d;

    always_comb begin
        cs_d    = conversion_start_n;
        sclk_d  = sclk;
        en_d    = en_q;
        nrise_d = nrise_q;
        since_d = (sclk && !sclk_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
        if (conversion_start_n && !cs_q) begin
            en_d    = 1'b1;
            nrise_d = 4'h0;
        end else if (!sclk && sclk_q && en_q && nrise_q == 4'h8) begin
            en_d    = 1'b0;
            nrise_d = 4'h0;
        end else if (sclk && !sclk_q && en_q && nrise_q != 4'h8) begin
            nrise_d = nrise_q + 4'h1;
        end
        // idle count saturates, only its threshold matters
        dis_d = en_q ? 4'h0 : dis_q + {3'h0, dis_q != 4'h8};
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cs_q    <= 1'b0;
            sclk_q  <= 1'b0;
            en_q    <= 1'b0;
            nrise_q <= 4'h0;
            since_q <= 4'hF;
            dis_q   <= 4'h0;
        end else begin
            cs_q    <= cs_d;
            sclk_q  <= sclk_d;
            en_q    <= en_d;
            nrise_q <= nrise_d;
            since_q <= since_d;
            dis_q   <= dis_d;
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    sequence s_first_rise;
        en_q && nrise_q == 4'h0 && !sclk ##1 sclk;
    endsequence
    sequence s_last_fall;
        en_q && nrise_q == 4'h8 && sclk ##1 !sclk;
    endsequence

    a_drive_after_enable: assert property ($fell(dout_oe_n) |-> en_q && nrise_q != 4'h0)
        else $error("data driven without an enabled port");
    a_first_bit_timing: assert property (s_first_rise |-> ##[2:5] !dout_oe_n)
        else $error("first bit not driven after first serial rise");
    a_release_eighth: assert property (s_last_fall |-> ##[2:5] dout_oe_n)
        else $error("data not released after eighth serial fall");
    a_held_until_last: assert property (en_q && !dout_oe_n && nrise_q != 4'h8 |=> !dout_oe_n)
        else $error("data released before eighth serial fall");
    a_dout_moves_on_rise: assert property (!dout_oe_n && $changed(dout) |-> since_q >= 4'h1 && since_q <= 4'h6)
        else $error("data bit changed away from a serial rise");
    a_quiet_when_idle: assert property (dis_q == 4'h8 |-> dout_oe_n && dout_line)
        else $error("data line driven while port disabled");
    a_no_read_span: assert property (sclk |-> conversion_start_n)
        else $error("serial clock high while start pin low");
    a_eight_rises_max: assert property (en_q && !sclk ##1 sclk |-> $past(nrise_q) != 4'h8)
        else $error("more than eight serial rises in one read");
    a_pin_low_width: assert property ($fell(conversion_start_n) |=> !conversion_start_n [*3])
        else $error("start pin low pulse too short");
endmodule : adc_link_assertions

`default_nettype wire

// file: test/adc_conversion_serial_control_tb.sv
// bench: host and converter joined, plus a second converter driven by hand
`timescale 1ns/1ns
`default_nettype none

module adc_conversion_serial_control_tb
    import adc_pkg::*;
;
    logic    clk, rst_n, start, auto_pd, done, busy, powered, converting, powered_2;
    result_t code, code_2, data, result, result_2, rd, c1, c2, c3;
    int      fails, n_tests, n_done, n_pd, conv_len;
    time     t_rise, t_conv;
    result_t corner [4] = '{8'h00, 8'hFF, 8'h80, 8'h01};

    adc_link_if link ();
    adc_link_if link_2 ();

    adc_device i_adc_device (.CLK_I(clk), .RESET_N_I(rst_n), .LINK(link), .ANALOG_CODE_I(code),
        .POWERED_O(powered), .CONVERTING_O(converting), .RESULT_O(result));
    adc_host i_adc_host (.CLK_I(clk), .RESET_N_I(rst_n), .START_I(start), .AUTO_PD_I(auto_pd),
        .LINK(link), .DATA_O(data), .DONE_O(done), .BUSY_O(busy));
    // second converter: the bench plays host and may bend the timing
    adc_device i_adc_device_2 (.CLK_I(clk), .RESET_N_I(rst_n), .LINK(link_2), .ANALOG_CODE_I(code_2),
        .POWERED_O(powered_2), .CONVERTING_O(), .RESULT_O(result_2));
    adc_link_assertions i_adc_link_assertions (.CLK_I(clk), .RESET_N_I(rst_n),
        .conversion_start_n(link.conversion_start_n), .sclk(link.sclk), .dout(link.dout),
        .dout_oe_n(link.dout_oe_n), .dout_line(link.dout_line));

    // ==========================================================
    // clock, monitors, watchdog
    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end

    always @(posedge clk) begin
        if (done === 1'b1) n_done <= n_done + 1;
        if (converting === 1'b1) conv_len <= conv_len + 1;
    end
    always @(negedge powered) n_pd++;
    // only the first wake and first conversion matter for the power-up span
    always @(posedge link.conversion_start_n) if (t_rise == 0) t_rise = $time;
    always @(posedge converting) if (t_conv == 0) t_conv = $time;

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end

    // ==========================================================
    // tasks and expectation helpers
    function automatic result_t next_bit(input result_t acc, input logic b);
        return {acc[6:0], b};
    endfunction : next_bit

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : check

    task automatic complete_run();
        if (fails == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic host_run(input logic mode, input result_t c);
        int d0, p0, l0, k;
        d0 = n_done;
        p0 = n_pd;
        l0 = conv_len;
        code = c;
        auto_pd = mode;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (30) @(negedge clk);
        // a second request while busy must be dropped
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        k = 0;
        while (n_done == d0 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        repeat (20) @(negedge clk);
        check("read byte", c, data);
        check("done count", 8'h01, 8'(n_done - d0));
        check("power downs", 8'(mode), 8'(n_pd - p0));
        check("conversion length", 8'(CONV_CYC), 8'(conv_len - l0));
        check("result", c, result);
        check("powered after read", 8'h01, 8'(powered));
        check("busy after read", 8'h00, 8'(busy));
    endtask : host_run

    task automatic pin(input logic v, input int n);
        link_2.conversion_start_n = v;
        repeat (n) @(negedge clk);
    endtask : pin

    // bench link clock: 400 ns period with random gaps; bit taken late in the high phase,
    // since the eighth fall releases the line
    task automatic read2(input int nbits, output result_t b);
        b = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            link_2.sclk = 1'b1;
            repeat (4) @(negedge clk);
            b = next_bit(b, link_2.dout_line);
            link_2.sclk = 1'b0;
            repeat (4) @(negedge clk);
            repeat ($urandom_range(3)) @(negedge clk);
        end
    endtask : read2

    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        auto_pd = 1'b0;
        code = 8'h00;
        code_2 = 8'h00;
        link_2.conversion_start_n = 1'b0;
        link_2.sclk = 1'b0;
        fails = 0;
        n_tests = 0;
        n_done = 0;
        n_pd = 0;
        conv_len = 0;
        t_rise = 0;
        t_conv = 0;
        void'($urandom(78944));
        repeat (8) @(negedge clk);
        check("pin at power-on", 8'h00, 8'(link.conversion_start_n));
        rst_n = 1'b1;
        host_run(1'b0, 8'hA5);
        check("power-up span", 8'h01, 8'(t_conv - t_rise >= 1000 && t_conv - t_rise <= 1300));
        foreach (corner[i]) host_run(1'(i % 2), corner[i]);
        repeat (4) host_run(1'($urandom_range(1)), 8'($urandom));
        c1 = 8'($urandom);
        c2 = 8'($urandom);
        c3 = 8'($urandom);
        read2(8, rd);
        check("read before any rise", 8'hFF, rd);
        pin(1'b1, 30);
        check("woken", 8'h01, 8'(powered_2));
        code_2 = c1;
        pin(1'b0, 120);
        check("auto power-down", 8'h00, 8'(powered_2));
        check("result two", c1, result_2);
        read2(8, rd);
        check("read while powered down", c1, rd);
        check("still powered down", 8'h00, 8'(powered_2));
        pin(1'b1, 4);
        read2(8, rd);
        check("read after wake", c1, rd);
        read2(2, rd);
        check("extra serial clocks", 8'h03, rd);
        code_2 = c2;
        pin(1'b0, 5);
        pin(1'b1, 30);
        read2(8, rd);
        check("read spanning end", c1, rd);
        check("high-speed stays up", 8'h01, 8'(powered_2));
        code_2 = c3;
        pin(1'b0, 4);
        pin(1'b1, 4);
        read2(8, rd);
        check("early read", c2, rd);
        repeat (110) @(negedge clk);
        check("result three", c3, result_2);
        complete_run();
    end
endmodule : adc_conversion_serial_control_tb

`default_nettype wire
